// ==== hw/hbc_pkg.sv ====
// Purpose: Constants for the hardware break comparator
// Assumes: One target bus cycle is marked by a one-cycle valid pulse
// Notes: Register address is {group, slot, field, 2'b00}
// Contract
// - Read direction qualifier counts matches only on read bus cycles.
// - Write direction qualifier counts matches only on write bus cycles.
// - Data-access status qualifier matches only processor data access cycles.
// - Transfer status qualifier matches only DMA or transfer controller cycles.
// - Probe pattern bits 3..0 compare probes 4..1, 0 low, 1 high.
// - Probe don't-care bits are left out of the comparison.
// - NMI condition matches when the NMI level equals the chosen level.
// - IRQ pattern bit n compares IRQ line n, 0 low, 1 high.
// - IRQ don't-care bits are left out of the comparison.
// - Pass count breaks only after the programmed number of matches, 1..0xffff.
// - Only channel 6 delays the stop by 1..0x7fff further bus cycles.
// - Direction, probe, NMI, IRQ, count and delay exist for groups A, B only.
// - Halt the user program when an enabled channel fully matches.
// - Groups A, B and C each have eight independent channels.
// - Sequential mode needs up to 7 points in order; reset point restarts.
// - Each channel has its own enable; group enable applies to all configured.
// - Inverted data condition matches when data differs from the value.
// - Byte comparison selects one of four lanes; lane 0 is the low byte.
package hbc_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_GRP = 3;
  localparam int NUM_QGRP = 2;
  localparam int GRP_C = 2;
  localparam int NUM_SLOT = 16;
  localparam int NUM_CHAN = 8;
  localparam int NUM_FLD = 10;
  localparam int SEQ_FIRST = 8;
  localparam int RST_SLOT = 15;
  localparam int DELAY_SLOT = 6;
  localparam logic [2:0] SEQ_LAST_STEP = 3'h6;
  localparam int REG_AW = 12;
  // ==========================================================
  // Address fields
  localparam int RA_GRP_LO = 10;
  localparam int RA_SLOT_LO = 6;
  localparam int RA_FLD_LO = 2;
  localparam logic [1:0] GRP_STAT = 2'h3;
  localparam logic [3:0] FLD_CTRL = 4'h0;
  localparam logic [3:0] FLD_ALO = 4'h1;
  localparam logic [3:0] FLD_AHI = 4'h2;
  localparam logic [3:0] FLD_ACARE = 4'h3;
  localparam logic [3:0] FLD_DATA = 4'h4;
  localparam logic [3:0] FLD_DCARE = 4'h5;
  localparam logic [3:0] FLD_PROBE = 4'h6;
  localparam logic [3:0] FLD_IRQ = 4'h7;
  localparam logic [3:0] FLD_COUNT = 4'h8;
  localparam logic [3:0] FLD_DELAY = 4'h9;
  localparam logic [3:0] FLD_GCMD = 4'hf;
  // ==========================================================
  // Channel control bits
  localparam int CB_EN = 0;
  localparam int CB_CFG = 1;
  localparam int CB_DIR_LO = 2;
  localparam int CB_ACC_LO = 4;
  localparam int CB_ANOT = 6;
  localparam int CB_DEN = 7;
  localparam int CB_DNOT = 8;
  localparam int CB_DW_LO = 9;
  localparam int CB_LANE_LO = 11;
  localparam int CB_NMIEN = 13;
  localparam int CB_NMILVL = 14;
  localparam int CB_AEN = 15;
  localparam logic [1:0] DIR_READ = 2'h1;
  localparam logic [1:0] DIR_WRITE = 2'h2;
  localparam logic [1:0] ACC_DATA = 2'h1;
  localparam logic [1:0] ACC_XFER = 2'h2;
  localparam logic [1:0] DW_BYTE = 2'h0;
  localparam logic [1:0] DW_WORD = 2'h1;
  // ==========================================================
  // Group command and status bits
  localparam int GC_SEQ = 0;
  localparam int GC_ENALL = 1;
  localparam int GC_DISALL = 2;
  localparam int GC_CLRALL = 3;
  localparam int GC_STEP_LO = 4;
  localparam int ST_HALT = 0;
  localparam int ST_GRP_LO = 1;
  localparam int ST_SLOT_LO = 3;
  // ==========================================================
  // Reset values and limits
  localparam logic [31:0] FLD_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0001;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [14:0] DELAY_ONE = 15'h0001;
  typedef enum logic {DLY_IDLE, DLY_COUNT} hbc_dly_e;
endpackage : hbc_pkg

// ==== hw/hbc_chan.sv ====
// Purpose: Combinational match of one break channel against one bus cycle
// Assumes: Enable gating is done by the caller
// Notes: QUAL is zero for group C, which matches on address and access status only
`timescale 1ns/1ns
module hbc_chan #(
  parameter bit QUAL = 1'b1
) (
  // Target bus cycle
  input wire logic [31:0] i_bus_addr,
  input wire logic [31:0] i_bus_data,
  input wire logic i_bus_wr,
  input wire logic i_transfer_controller_cycle,
  input wire logic [3:0] i_probe,
  input wire logic i_nmi,
  input wire logic [7:0] i_irq,
  // Channel settings
  input wire logic [31:0] i_ctrl,
  input wire logic [31:0] i_addr_lo,
  input wire logic [31:0] i_addr_hi,
  input wire logic [31:0] i_addr_care,
  input wire logic [31:0] i_data,
  input wire logic [31:0] i_data_care,
  input wire logic [31:0] i_probe_cfg,
  input wire logic [31:0] i_irq_cfg,
  // Result
  output logic o_match
);
  import hbc_pkg::*;

  function automatic logic eq_care(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] care);
    eq_care = ((a ^ b) & care) == 32'h0000_0000;
  endfunction : eq_care

  logic [31:0] am;
  logic [31:0] lane_m;
  logic [31:0] dval;
  logic [4:0] sh;
  logic addr_ok;
  logic data_ok;
  logic dir_ok;
  logic acc_ok;
  logic probe_ok;
  logic irq_ok;
  logic nmi_ok;

  // ==========================================================
  // Qualifier terms
  always_comb begin
    am = i_bus_addr & i_addr_care;
    addr_ok = !i_ctrl[CB_AEN] ||
      (((am >= (i_addr_lo & i_addr_care)) && (am <= (i_addr_hi & i_addr_care)))
       ^ i_ctrl[CB_ANOT]);
    sh = {i_ctrl[CB_LANE_LO +: 2], 3'h0};
    if (i_ctrl[CB_DW_LO +: 2] == DW_BYTE) begin
      lane_m = 32'h0000_00ff << sh;
    end else if (i_ctrl[CB_DW_LO +: 2] == DW_WORD) begin
      sh = {i_ctrl[CB_LANE_LO], 4'h0};
      lane_m = 32'h0000_ffff << sh;
    end else begin
      sh = 5'h00;
      lane_m = 32'hffff_ffff;
    end
    dval = i_data << sh;
    data_ok = !i_ctrl[CB_DEN] ||
      (eq_care(i_bus_data, dval, lane_m & i_data_care) ^ i_ctrl[CB_DNOT]);
    dir_ok = !((i_ctrl[CB_DIR_LO +: 2] == DIR_READ) && i_bus_wr) &&
      !((i_ctrl[CB_DIR_LO +: 2] == DIR_WRITE) && !i_bus_wr);
    acc_ok = !((i_ctrl[CB_ACC_LO +: 2] == ACC_DATA) && i_transfer_controller_cycle) &&
      !((i_ctrl[CB_ACC_LO +: 2] == ACC_XFER) && !i_transfer_controller_cycle);
    probe_ok = eq_care({28'h0, i_probe}, {28'h0, i_probe_cfg[3:0]},
                       {28'h0, i_probe_cfg[7:4]});
    irq_ok = eq_care({24'h0, i_irq}, {24'h0, i_irq_cfg[7:0]},
                     {24'h0, i_irq_cfg[15:8]});
    nmi_ok = !i_ctrl[CB_NMIEN] || (i_nmi == i_ctrl[CB_NMILVL]);
    if (QUAL) begin
      o_match = addr_ok && data_ok && dir_ok && acc_ok && probe_ok && irq_ok && nmi_ok;
    end else begin
      o_match = addr_ok && acc_ok;
    end
  end
endmodule : hbc_chan

// ==== hw/hbc_top.sv ====
// Purpose: Hardware break comparator with three channel groups
// Assumes: Bus, probe and interrupt inputs are synchronous to i_core_clk
// Notes: Halt request stays high until software clears it
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
module hbc_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [hbc_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Target bus cycle
  input wire logic i_bus_valid,
  input wire logic [31:0] i_bus_addr,
  input wire logic [31:0] i_bus_data,
  input wire logic i_bus_wr,
  input wire logic i_transfer_controller_cycle,
  // Probe and interrupt pins
  input wire logic [3:0] i_probe,
  input wire logic i_nmi,
  input wire logic [7:0] i_irq,
  // Break output
  output logic o_halt_req,
  output logic [1:0] o_halt_grp,
  output logic [3:0] o_halt_slot
);
  import hbc_pkg::*;

  logic [31:0] cfg_q [NUM_GRP][NUM_SLOT][NUM_FLD];
  logic [31:0] cfg_d [NUM_GRP][NUM_SLOT][NUM_FLD];
  logic [NUM_GRP-1:0] seq_q;
  logic [NUM_GRP-1:0] seq_d;
  logic [15:0] cnt_q [NUM_QGRP][NUM_CHAN];
  logic [15:0] cnt_d [NUM_QGRP][NUM_CHAN];
  logic [2:0] step_q [NUM_QGRP];
  logic [2:0] step_d [NUM_QGRP];
  hbc_dly_e dly_st_q [NUM_QGRP];
  hbc_dly_e dly_st_d [NUM_QGRP];
  logic [14:0] dly_cnt_q [NUM_QGRP];
  logic [14:0] dly_cnt_d [NUM_QGRP];
  logic halt_q;
  logic halt_d;
  logic [1:0] src_grp_q;
  logic [1:0] src_grp_d;
  logic [3:0] src_slot_q;
  logic [3:0] src_slot_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NUM_SLOT-1:0] match_w [NUM_GRP];
  logic [NUM_SLOT-1:0] hit_w [NUM_GRP];
  logic [1:0] ra_grp;
  logic [3:0] ra_slot;
  logic [3:0] ra_fld;
  logic stat_clr;

  assign ra_grp = i_reg_addr[RA_GRP_LO +: 2];
  assign ra_slot = i_reg_addr[RA_SLOT_LO +: 4];
  assign ra_fld = i_reg_addr[RA_FLD_LO +: 4];
  assign stat_clr = i_reg_wr && (ra_grp == GRP_STAT) && i_reg_wdata[ST_HALT];

  // ==========================================================
  // Channel comparators
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
      hbc_chan #(
        .QUAL(g != GRP_C)
      ) u_chan (
        .i_bus_addr(i_bus_addr),
        .i_bus_data(i_bus_data),
        .i_bus_wr(i_bus_wr),
        .i_transfer_controller_cycle(i_transfer_controller_cycle),
        .i_probe(i_probe),
        .i_nmi(i_nmi),
        .i_irq(i_irq),
        .i_ctrl(cfg_q[g][s][FLD_CTRL]),
        .i_addr_lo(cfg_q[g][s][FLD_ALO]),
        .i_addr_hi(cfg_q[g][s][FLD_AHI]),
        .i_addr_care(cfg_q[g][s][FLD_ACARE]),
        .i_data(cfg_q[g][s][FLD_DATA]),
        .i_data_care(cfg_q[g][s][FLD_DCARE]),
        .i_probe_cfg(cfg_q[g][s][FLD_PROBE]),
        .i_irq_cfg(cfg_q[g][s][FLD_IRQ]),
        .o_match(match_w[g][s])
      );
      assign hit_w[g][s] = match_w[g][s] && cfg_q[g][s][FLD_CTRL][CB_EN] &&
        cfg_q[g][s][FLD_CTRL][CB_CFG];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    int pt;
    logic fire;
    logic [1:0] f_grp;
    logic [3:0] f_slot;
    pt = 0;
    fire = 1'b0;
    f_grp = 2'h0;
    f_slot = 4'h0;
    cfg_d = cfg_q;
    seq_d = seq_q;
    cnt_d = cnt_q;
    step_d = step_q;
    dly_st_d = dly_st_q;
    dly_cnt_d = dly_cnt_q;
    halt_d = halt_q;
    src_grp_d = src_grp_q;
    src_slot_d = src_slot_q;
    rdata_d = 32'h0000_0000;
    if (i_bus_valid && !halt_q) begin
      for (int g = 0; g < NUM_QGRP; g++) begin
        if (dly_st_q[g] == DLY_COUNT) begin
          if (dly_cnt_q[g] <= DELAY_ONE) begin
            dly_st_d[g] = DLY_IDLE;
            if (!fire) begin
              fire = 1'b1;
              f_grp = 2'(g);
              f_slot = 4'(DELAY_SLOT);
            end
          end else begin
            dly_cnt_d[g] = dly_cnt_q[g] - DELAY_ONE;
          end
        end
        if (seq_q[g]) begin
          pt = SEQ_FIRST + int'(step_q[g]);
          if (hit_w[g][RST_SLOT]) begin
            step_d[g] = 3'h0;
          end else if (hit_w[g][pt]) begin
            if (step_q[g] == SEQ_LAST_STEP || !cfg_q[g][pt + 1][FLD_CTRL][CB_CFG]) begin
              step_d[g] = 3'h0;
              if (!fire) begin
                fire = 1'b1;
                f_grp = 2'(g);
                f_slot = 4'(pt);
              end
            end else begin
              step_d[g] = step_q[g] + 3'h1;
            end
          end
        end else begin
          for (int c = 0; c < NUM_CHAN; c++) begin
            if (hit_w[g][c]) begin
              if ((cnt_q[g][c] + COUNT_ONE) >= cfg_q[g][c][FLD_COUNT][15:0]) begin
                cnt_d[g][c] = 16'h0000;
                if (c == DELAY_SLOT && cfg_q[g][c][FLD_DELAY][14:0] != 15'h0000) begin
                  if (dly_st_q[g] == DLY_IDLE) begin
                    dly_st_d[g] = DLY_COUNT;
                    dly_cnt_d[g] = cfg_q[g][c][FLD_DELAY][14:0];
                  end
                end else if (!fire) begin
                  fire = 1'b1;
                  f_grp = 2'(g);
                  f_slot = 4'(c);
                end
              end else begin
                cnt_d[g][c] = cnt_q[g][c] + COUNT_ONE;
              end
            end
          end
        end
      end
      for (int c = NUM_CHAN - 1; c >= 0; c--) begin
        if (hit_w[GRP_C][c] && !fire) begin
          f_grp = 2'(GRP_C);
          f_slot = 4'(c);
        end
      end
      if (!fire && |hit_w[GRP_C][NUM_CHAN-1:0]) begin
        fire = 1'b1;
      end
    end
    if (stat_clr) begin
      halt_d = 1'b0;
    end
    if (fire) begin
      halt_d = 1'b1;
      src_grp_d = f_grp;
      src_slot_d = f_slot;
    end
    if (i_reg_wr && ra_grp != GRP_STAT) begin
      if (ra_fld == FLD_GCMD) begin
        seq_d[ra_grp] = i_reg_wdata[GC_SEQ] && (ra_grp != 2'(GRP_C));
        for (int s = 0; s < NUM_SLOT; s++) begin
          if (i_reg_wdata[GC_ENALL] && cfg_q[ra_grp][s][FLD_CTRL][CB_CFG]) begin
            cfg_d[ra_grp][s][FLD_CTRL][CB_EN] = 1'b1;
          end
          if (i_reg_wdata[GC_DISALL]) begin
            cfg_d[ra_grp][s][FLD_CTRL][CB_EN] = 1'b0;
          end
          if (i_reg_wdata[GC_CLRALL]) begin
            for (int f = 0; f < NUM_FLD; f++) begin
              cfg_d[ra_grp][s][f] = FLD_RST;
            end
            cfg_d[ra_grp][s][FLD_COUNT] = COUNT_RST;
          end
        end
        if (i_reg_wdata[GC_CLRALL] && ra_grp != 2'(GRP_C)) begin
          step_d[ra_grp[0]] = 3'h0;
          dly_st_d[ra_grp[0]] = DLY_IDLE;
          for (int c = 0; c < NUM_CHAN; c++) begin
            cnt_d[ra_grp[0]][c] = 16'h0000;
          end
        end
      end else if (int'(ra_fld) < NUM_FLD) begin
        cfg_d[ra_grp][ra_slot][ra_fld] = i_reg_wdata;
      end
    end
    if (i_reg_rd) begin
      if (ra_grp == GRP_STAT) begin
        rdata_d[ST_HALT] = halt_q;
        rdata_d[ST_GRP_LO +: 2] = src_grp_q;
        rdata_d[ST_SLOT_LO +: 4] = src_slot_q;
      end else if (ra_fld == FLD_GCMD) begin
        rdata_d[GC_SEQ] = seq_q[ra_grp];
        if (ra_grp != 2'(GRP_C)) begin
          rdata_d[GC_STEP_LO +: 3] = step_q[ra_grp[0]];
        end
      end else if (int'(ra_fld) < NUM_FLD) begin
        rdata_d = cfg_q[ra_grp][ra_slot][ra_fld];
      end
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        for (int s = 0; s < NUM_SLOT; s++) begin
          for (int f = 0; f < NUM_FLD; f++) begin
            cfg_q[g][s][f] <= (f == int'(FLD_COUNT)) ? COUNT_RST : FLD_RST;
          end
        end
      end
      for (int g = 0; g < NUM_QGRP; g++) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          cnt_q[g][c] <= 16'h0000;
        end
        step_q[g] <= 3'h0;
        dly_st_q[g] <= DLY_IDLE;
        dly_cnt_q[g] <= 15'h0000;
      end
      seq_q <= '0;
      halt_q <= 1'b0;
      src_grp_q <= 2'h0;
      src_slot_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      dly_st_q <= dly_st_d;
      dly_cnt_q <= dly_cnt_d;
      seq_q <= seq_d;
      halt_q <= halt_d;
      src_grp_q <= src_grp_d;
      src_slot_q <= src_slot_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_halt_req = halt_q;
  assign o_halt_grp = src_grp_q;
  assign o_halt_slot = src_slot_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  halt_sticky_a: assert property (halt_q && !stat_clr |=> halt_q)
    else $error("halt dropped without clear");
  grpc_break_a: assert property (i_bus_valid && !halt_q && |hit_w[GRP_C][NUM_CHAN-1:0] &&
    hit_w[0] == '0 && hit_w[1] == '0 && dly_st_q[0] == DLY_IDLE && dly_st_q[1] == DLY_IDLE
    |=> halt_q && src_grp_q == 2'h2)
    else $error("group C hit did not halt");
  disabled_idle_a: assert property (i_bus_valid && !cfg_q[0][0][FLD_CTRL][CB_EN] && !i_reg_wr
    |=> cnt_q[0][0] == $past(cnt_q[0][0]))
    else $error("disabled channel advanced its count");
  count_step_a: assert property (i_bus_valid && !halt_q && !seq_q[1] && hit_w[1][2] &&
    !i_reg_wr && (cnt_q[1][2] + COUNT_ONE) < cfg_q[1][2][FLD_COUNT][15:0]
    |=> cnt_q[1][2] == $past(cnt_q[1][2]) + COUNT_ONE &&
    !(halt_q && src_grp_q == 2'h1 && src_slot_q == 4'h2))
    else $error("pass count did not advance");
  delay_hold_a: assert property (dly_st_q[0] == DLY_COUNT && !i_bus_valid && !i_reg_wr
    |=> $stable(dly_cnt_q[0]) && dly_st_q[0] == DLY_COUNT)
    else $error("delay moved without a bus cycle");
  seq_restart_a: assert property (seq_q[0] && i_bus_valid && !halt_q && hit_w[0][RST_SLOT] &&
    !i_reg_wr |=> step_q[0] == 3'h0)
    else $error("reset point did not restart sequence");
  seq_chan_a: assert property (seq_q[0] && !i_reg_wr |=> $stable(cnt_q[0][0]))
    else $error("channel counted in sequential mode");
  status_read_a: assert property (i_reg_rd && ra_grp == GRP_STAT |=>
    o_reg_rdata[ST_HALT] == $past(halt_q) && o_reg_rdata[ST_SLOT_LO +: 4] == $past(src_slot_q))
    else $error("status read mismatch");
endmodule : hbc_top

// ==== test/hbc_bus_model.sv ====
// Purpose: Target bus, probe and interrupt pin model
// Assumes: One bus cycle is a one-clock valid pulse
// Notes: Released bus lines show the inverse of the last value
`timescale 1ns/1ns
module hbc_bus_model (
  // Clock
  input wire logic i_clk,
  // Bus and pins
  output logic o_valid,
  output logic [31:0] o_addr,
  output logic [31:0] o_data,
  output logic o_wr,
  output logic o_xfer,
  output logic [3:0] o_probe,
  output logic o_nmi,
  output logic [7:0] o_irq
);
  initial begin
    o_valid = 1'b0;
    {o_addr, o_data, o_wr, o_xfer} = '0;
    {o_probe, o_nmi, o_irq} = '0;
  end
  // ==========================================================
  // One bus cycle after gap idle clocks
  task automatic cycle(input logic [31:0] a, d, input logic w, x, input logic [3:0] p,
                       input logic n, input logic [7:0] q, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_valid <= 1'b1;
    {o_addr, o_data, o_wr, o_xfer} <= {a, d, w, x};
    {o_probe, o_nmi, o_irq} <= {p, n, q};
    @(posedge i_clk);
    o_valid <= 1'b0;
    {o_addr, o_data, o_wr, o_xfer} <= ~{a, d, w, x};
  endtask : cycle
endmodule : hbc_bus_model

// ==== test/hbc_top_test.sv ====
// Purpose: Self-checking bench for the break comparator
// Assumes: Register port answers one cycle after a read strobe
// Notes: Expected halts of the random loop come from a behavioural channel model
`timescale 1ns/1ns
module hbc_top_test;
  import hbc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [REG_AW-1:0] i_reg_addr = '0;
  logic [31:0] i_reg_wdata = '0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata, i_bus_addr, i_bus_data;
  logic i_bus_valid, i_bus_wr, i_transfer_controller_cycle, i_nmi, o_halt_req;
  logic [3:0] i_probe, o_halt_slot;
  logic [7:0] i_irq;
  logic [1:0] o_halt_grp;
  int error_cnt = 0;
  int n_checks = 0;
  always #10 i_core_clk = ~i_core_clk;
  hbc_top hbc_top_inst (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_bus_valid, .i_bus_addr, .i_bus_data, .i_bus_wr,
    .i_transfer_controller_cycle, .i_probe, .i_nmi, .i_irq, .o_halt_req, .o_halt_grp,
    .o_halt_slot);
  hbc_bus_model hbc_bus_model_inst (.i_clk(i_core_clk), .o_valid(i_bus_valid),
    .o_addr(i_bus_addr), .o_data(i_bus_data), .o_wr(i_bus_wr),
    .o_xfer(i_transfer_controller_cycle), .o_probe(i_probe), .o_nmi(i_nmi), .o_irq(i_irq));
  // ==========================================================
  // Register port and checks
  function automatic logic [REG_AW-1:0] ra(input int g, s, f);
    return {g[1:0], s[3:0], f[3:0], 2'b00};
  endfunction : ra
  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : reg_rd
  task automatic chk_reg(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_halt(input logic [6:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t halt got %h exp %h", $time, got, exp);
    end
  endtask : chk_halt
  task automatic exp_halt(input bit h, input int g, s);
    if (h) begin
      chk_halt({o_halt_req, o_halt_grp, o_halt_slot}, {1'b1, g[1:0], s[3:0]});
    end else begin
      chk_halt({o_halt_req, 6'h0}, 7'h0);
    end
  endtask : exp_halt
  task automatic clear_grp(input int g);
    reg_wr(ra(g, 0, FLD_GCMD), 32'h8);
    reg_wr(ra(3, 0, 0), 32'h1);
  endtask : clear_grp
  task automatic bus(input logic [31:0] a, d, input logic w, x, n);
    hbc_bus_model_inst.cycle(a, d, w, x, 4'h0, n, 8'h0, 1);
    #1;
  endtask : bus
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Channel model for groups A and B
  function automatic bit exp_hit(input logic [31:0] c, p, r, input logic w, x, n,
                                 input logic [3:0] pr, input logic [7:0] iq);
    bit h;
    h = c[CB_EN] && c[CB_CFG];
    if ((c[CB_ACC_LO +: 2] == ACC_DATA && x) || (c[CB_ACC_LO +: 2] == ACC_XFER && !x)) h = 0;
    if ((c[CB_DIR_LO +: 2] == DIR_READ && w) || (c[CB_DIR_LO +: 2] == DIR_WRITE && !w)) h = 0;
    if (((pr ^ p[3:0]) & p[7:4]) != 4'h0) h = 0;
    if (c[CB_NMIEN] && n != c[CB_NMILVL]) h = 0;
    if (((iq ^ r[7:0]) & r[15:8]) != 8'h0) h = 0;
    return h;
  endfunction : exp_hit
  // ==========================================================
  // Watchdog
  initial begin
    repeat (100000) @(posedge i_core_clk);
    error_cnt++;
    end_of_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] c, p, r, d;
    logic w, x, n;
    logic [3:0] pr;
    logic [7:0] iq;
    int g, s;
    bit hit;
    void'($urandom(32'hc09ad3e2));
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    reg_rd(ra(0, 0, FLD_CTRL), d);
    chk_reg(d, FLD_RST);
    reg_rd(ra(1, 3, FLD_COUNT), d);
    chk_reg(d, COUNT_RST);
    reg_rd(ra(0, 0, 10), d);
    chk_reg(d, 32'h0);
    for (int i = 0; i < 60; i++) begin
      g = $urandom_range(1);
      s = $urandom_range(7);
      c = 32'h2 | 32'(($urandom_range(3) != 0)) | ($urandom_range(2) << CB_DIR_LO);
      c = c | ($urandom_range(2) << CB_ACC_LO) | ($urandom & 32'h6000);
      p = $urandom & $urandom & 32'hff;
      r = $urandom & ($urandom | 32'hff) & ($urandom | 32'hff) & 32'hffff;
      reg_wr(ra(g, s, FLD_PROBE), p);
      reg_wr(ra(g, s, FLD_IRQ), r);
      reg_wr(ra(g, s, FLD_CTRL), c);
      hit = 0;
      for (int k = 0; k < 8 && !hit; k++) begin
        {w, x, n, pr, iq} = 15'($urandom);
        hbc_bus_model_inst.cycle($urandom, $urandom, w, x, pr, n, iq, $urandom_range(2));
        #1 hit = exp_hit(c, p, r, w, x, n, pr, iq);
        exp_halt(hit, g, s);
      end
      clear_grp(g);
    end
    reg_wr(ra(1, 2, FLD_COUNT), 32'h3);
    reg_wr(ra(1, 2, FLD_CTRL), 32'h3 | (DIR_WRITE << CB_DIR_LO));
    for (int k = 1; k <= 3; k++) begin
      bus(32'h100, 32'h0, 1'b0, 1'b0, 1'b0);
      exp_halt(0, 1, 2);
      bus(32'h100, 32'h0, 1'b1, 1'b0, 1'b0);
      exp_halt(k == 3, 1, 2);
    end
    clear_grp(1);
    reg_wr(ra(0, DELAY_SLOT, FLD_DELAY), 32'h2);
    reg_wr(ra(0, DELAY_SLOT, FLD_CTRL), 32'h3 | (ACC_XFER << CB_ACC_LO));
    for (int k = 0; k < 3; k++) begin
      bus(32'h0, 32'h0, 1'b0, k == 0, 1'b0);
      exp_halt(k == 2, 0, DELAY_SLOT);
    end
    clear_grp(0);
    reg_wr(ra(2, DELAY_SLOT, FLD_DELAY), 32'h2);
    reg_wr(ra(2, DELAY_SLOT, FLD_COUNT), 32'h3);
    reg_wr(ra(2, DELAY_SLOT, FLD_CTRL), 32'h2003 | (DIR_WRITE << CB_DIR_LO));
    bus(32'h0, 32'h0, 1'b0, 1'b0, 1'b1);
    exp_halt(1, 2, DELAY_SLOT);
    clear_grp(2);
    reg_wr(ra(0, 0, FLD_DATA), 32'h4750);
    reg_wr(ra(0, 0, FLD_DCARE), 32'hffffffff);
    reg_wr(ra(0, 0, FLD_CTRL), 32'h583);
    bus(32'h0, 32'h4750, 1'b0, 1'b0, 1'b0);
    exp_halt(0, 0, 0);
    bus(32'h0, 32'h4751, 1'b0, 1'b0, 1'b0);
    exp_halt(1, 0, 0);
    clear_grp(0);
    reg_wr(ra(0, 0, FLD_DATA), 32'h47);
    reg_wr(ra(0, 0, FLD_DCARE), 32'hffffffff);
    reg_wr(ra(0, 0, FLD_CTRL), 32'h1083);
    bus(32'h0, 32'h47, 1'b0, 1'b0, 1'b0);
    exp_halt(0, 0, 0);
    bus(32'h0, 32'h470000, 1'b0, 1'b0, 1'b0);
    exp_halt(1, 0, 0);
    clear_grp(0);
    reg_wr(ra(0, 0, FLD_GCMD), 32'h1);
    for (int k = 0; k < 3; k++) begin
      s = (k == 2) ? RST_SLOT : SEQ_FIRST + k;
      reg_wr(ra(0, s, FLD_ALO), 32'h1000 * (k + 1));
      reg_wr(ra(0, s, FLD_AHI), 32'h1000 * (k + 1));
      reg_wr(ra(0, s, FLD_ACARE), 32'hffffffff);
      reg_wr(ra(0, s, FLD_CTRL), 32'h8002);
    end
    reg_wr(ra(0, 0, FLD_GCMD), 32'h3);
    for (int k = 0; k < 6; k++) begin
      bus(32'h1000 * ((32'h215231 >> (4 * k)) & 32'hf), 32'h0, 1'b0, 1'b0, 1'b0);
      exp_halt(k == 5, 0, SEQ_FIRST + 1);
    end
    clear_grp(0);
    reg_rd(ra(0, SEQ_FIRST, FLD_CTRL), d);
    chk_reg(d, 32'h0);
    reg_rd(ra(0, 0, FLD_GCMD), d);
    chk_reg(d, 32'h0);
    reg_wr(ra(1, 0, FLD_CTRL), 32'h2);
    reg_wr(ra(1, 1, FLD_CTRL), 32'h2);
    bus(32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
    exp_halt(0, 1, 0);
    reg_wr(ra(1, 0, FLD_GCMD), 32'h2);
    bus(32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
    exp_halt(1, 1, 0);
    reg_wr(ra(3, 0, 0), 32'h1);
    reg_wr(ra(1, 0, FLD_GCMD), 32'h4);
    bus(32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
    exp_halt(0, 1, 0);
    end_of_test();
  end
endmodule : hbc_top_test
